// file: include/frctd_pkg.sv
package frctd_pkg;

  // ----------------------------------------------------------------
  // Control word layout (low byte of the oscillator control word)
  // ----------------------------------------------------------------
  localparam int          SEQEN_BIT     = 2;
  localparam int          RNDEN_BIT     = 3;
  localparam int          LOCK_BIT      = 5;
  localparam logic [7:0]  UNLOCK_KEY1   = 8'h46;
  localparam logic [7:0]  UNLOCK_KEY2   = 8'h57;

  // ----------------------------------------------------------------
  // Tuning, dithering and source codes
  // ----------------------------------------------------------------
  localparam logic [3:0]  TUNE_CENTER   = 4'h0;
  localparam logic [3:0]  TUNE_MAX      = 4'h7;
  localparam logic [3:0]  TUNE_MIN      = 4'h8;
  localparam logic [2:0]  DITHER_PERIOD = 3'h7;  // Retune every 8th cycle
  localparam logic [2:0]  SRC_FRC       = 3'h0;
  localparam logic [2:0]  SRC_FRC_PLL   = 3'h1;
  localparam logic [2:0]  SRC_PRI       = 3'h2;
  localparam logic [2:0]  SRC_PRI_PLL   = 3'h3;
  localparam logic [5:0]  PLL_MULT      = 6'h20; // Fixed factor of 32
  localparam logic [14:0] SEED_RESET    = 15'h0000;
  localparam logic [14:0] SEED_ZERO_SUB = 15'h0001; // Avoids LFSR lock-up
  localparam logic [14:0] LFSR_TAPS     = 15'h6000; // x^15 + x^14 + 1

  // ----------------------------------------------------------------
  // Timing counts at 10 MHz
  // ----------------------------------------------------------------
  localparam int          CLK_HZ        = 10000000;
  localparam int          LOCK_TIME_US  = 50;
  localparam int          LOCK_CYCLES   = (LOCK_TIME_US * (CLK_HZ / 1000000));
  localparam logic [15:0] FREQ_LOW_KHZ  = 16'h25e4;  // 9700 kHz
  localparam logic [15:0] FREQ_HIGH_KHZ = 16'h38d6;  // 14550 kHz
  localparam logic [15:0] LOW_POWER_RC_OSC_KHZ      = 16'h0020;  // 32 kHz

endpackage : frctd_pkg

// file: verilog/frctd_lfsr.sv
`timescale 1ns/1ns
// ------------------------------------------------------------------
// Pseudo-random code generator with software seed load
// ------------------------------------------------------------------
module frctd_lfsr (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // Seed load
  input  wire logic        seed_we_i,
  input  wire logic [14:0] seed_i,
  // Advance
  input  wire logic        step_i,
  output logic      [14:0] state_o
);

  logic [14:0] lfsr_q;
  logic        fb;

  // Feedback is the parity of the tapped bits
  assign fb      = ^(lfsr_q & frctd_pkg::LFSR_TAPS);
  assign state_o = lfsr_q;

  // Seed write wins over a step so software sees its value
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lfsr_q <= frctd_pkg::SEED_RESET;
    end else if (seed_we_i) begin
      lfsr_q <= seed_i;
    end else if (step_i) begin
      if (lfsr_q == frctd_pkg::SEED_RESET) begin
        lfsr_q <= frctd_pkg::SEED_ZERO_SUB;  // All-zero would never move
      end else begin
        lfsr_q <= {lfsr_q[13:0], fb};
      end
    end
  end

endmodule : frctd_lfsr

// file: verilog/frctd_ctrl.sv
`timescale 1ns/1ns
// Functional notes
// - Range bit 1 selects 14.55 MHz, bit 0 selects 9.7 MHz.
// - Tune code is two's complement: 0 centre, 7 max, 8 min.
// - Both dither enables low: tune from base_tune_code only.
// - Sequencer: every 8th PWM cycle step base then codes 1 to 7.
// - Random dither: pseudo-random 4-bit code every 8th PWM cycle.
// - Software may write a seed into the shift register.
// - Low byte 0x46 then 0x57 back to back unlocks enable change.
// - Source code 001 selects fast RC with PLL at power-on.
// - The PLL always multiplies by 32.
// - Lock wait applies when PLL is selected at reset or switch.
// - Lock wait starts only once PLL input clock is present.
// - Lock flag at bit 5, clears on reset and PLL switch.
// - Lock flag stays clear while source does not use PLL.
// - Low-power RC is 32 kHz, clocks timers and clock monitor.
// - Low-power RC on at reset per delay select, kept if needed.
// - Low-power RC is always off in sleep.
// - Low-power RC usable at once, no start-up counter.
// - Source code 000 selects fast RC without PLL at power-on.
// - Seed register is 15 bits, bit 15 reads zero, resets zero.
// - Tune register 2 holds codes 6, 5, 4 at 11:8, 7:4, 3:0.
module frctd_ctrl (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  // Configuration word
  input  wire logic        frc_range_select_i,
  input  wire logic [2:0]  initial_osc_select_i,
  input  wire logic [2:0]  powerup_delay_select_i,
  input  wire logic        clock_fail_monitor_en_i,
  input  wire logic        watchdog_en_i,
  // Control word low-byte writes
  input  wire logic        ctrl_low_we_i,
  input  wire logic [7:0]  ctrl_low_wdata_i,
  // Tune registers
  input  wire logic        tune_we_i,
  input  wire logic [15:0] tune_wdata_i,
  input  wire logic        tune2_we_i,
  input  wire logic [15:0] tune2_wdata_i,
  input  wire logic        seed_we_i,
  input  wire logic [15:0] seed_wdata_i,
  // Clock system events
  input  wire logic        pwm_cycle_i,
  input  wire logic        switch_start_i,
  input  wire logic [2:0]  switch_src_i,
  input  wire logic        pll_input_ready_i,
  input  wire logic        power_up_timer_done_i,
  input  wire logic        sleep_i,
  // Outputs
  output logic [3:0]       tune_code_o,
  output logic [15:0]      frc_freq_khz_o,
  output logic [5:0]       pll_mult_o,
  output logic [7:0]       ctrl_low_rdata_o,
  output logic [15:0]      tune_rdata_o,
  output logic [15:0]      tune2_rdata_o,
  output logic [15:0]      seed_rdata_o,
  output logic             pll_lock_flag_o,
  output logic             low_power_rc_osc_enable_o,
  output logic             low_power_rc_osc_ready_o
);

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n;

  // Release is synchronised; assertion stays asynchronous
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Unlock sequence and dither enables
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {UNL_IDLE, UNL_KEY1, UNL_OPEN} frctd_unl_e;
  frctd_unl_e unl_q;
  logic       seq_en_q;
  logic       rnd_en_q;

  // Any write out of order falls back to idle; a repeated first key stays armed
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      unl_q <= UNL_IDLE;
    end else if (ctrl_low_we_i) begin
      unique case (unl_q)
        UNL_IDLE: unl_q <= (ctrl_low_wdata_i == frctd_pkg::UNLOCK_KEY1)
                           ? UNL_KEY1 : UNL_IDLE;
        UNL_KEY1: unl_q <= (ctrl_low_wdata_i == frctd_pkg::UNLOCK_KEY2)
                           ? UNL_OPEN
                           : ((ctrl_low_wdata_i == frctd_pkg::UNLOCK_KEY1)
                              ? UNL_KEY1 : UNL_IDLE);
        UNL_OPEN: unl_q <= UNL_IDLE;          // One write only, then shut
      endcase
    end
  end

  // Enables change only on the write right after the second key
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      seq_en_q <= 1'b0;
      rnd_en_q <= 1'b0;
    end else if (ctrl_low_we_i && unl_q == UNL_OPEN) begin
      seq_en_q <= ctrl_low_wdata_i[frctd_pkg::SEQEN_BIT];
      rnd_en_q <= ctrl_low_wdata_i[frctd_pkg::RNDEN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Tune registers
  // ----------------------------------------------------------------
  logic [3:0] code_q [8];  // Entry 0 is the base code, 1..7 the sequence

  // Register 1 holds base and codes 1..3, register 2 codes 4..7
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        code_q[i] <= frctd_pkg::TUNE_CENTER;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (tune_we_i) begin
          code_q[i] <= tune_wdata_i[4*i +: 4];
        end
        if (tune2_we_i) begin
          code_q[i+4] <= tune2_wdata_i[4*i +: 4];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Dither pacing and code selection
  // ----------------------------------------------------------------
  logic [2:0]  pwm_cnt_q;
  logic [2:0]  seq_idx_q;
  logic [3:0]  rnd_code_q;
  logic [14:0] lfsr_state;
  logic        dither_on;
  logic        retune;

  assign dither_on = seq_en_q | rnd_en_q;
  assign retune    = dither_on && pwm_cycle_i &&
                     (pwm_cnt_q == frctd_pkg::DITHER_PERIOD);

  // Counts PWM cycles only while dithering, so the count starts fresh each time dithering turns on from off
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pwm_cnt_q <= 3'h0;
    end else if (!dither_on) begin
      pwm_cnt_q <= 3'h0;
    end else if (pwm_cycle_i) begin
      pwm_cnt_q <= pwm_cnt_q + 3'h1;
    end
  end

  // Sequence index starts at the base code and wraps after code 7
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      seq_idx_q <= 3'h0;
    end else if (!seq_en_q || rnd_en_q) begin
      seq_idx_q <= 3'h0;
    end else if (retune) begin
      seq_idx_q <= seq_idx_q + 3'h1;
    end
  end

  frctd_lfsr u_lfsr (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n),
    .seed_we_i (seed_we_i),
    .seed_i    (seed_wdata_i[14:0]),
    .step_i    (retune && rnd_en_q),
    .state_o   (lfsr_state)
  );

  // Random code is latched at each retune so it holds between them
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rnd_code_q <= frctd_pkg::TUNE_CENTER;
    end else if (rnd_en_q && retune) begin
      rnd_code_q <= lfsr_state[3:0];
    end
  end

  // Applied code; random dither has priority over the sequencer
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      tune_code_o <= frctd_pkg::TUNE_CENTER;
    end else if (rnd_en_q) begin
      tune_code_o <= rnd_code_q;
    end else if (seq_en_q) begin
      tune_code_o <= code_q[seq_idx_q];
    end else begin
      tune_code_o <= code_q[0];
    end
  end

  // Nominal range; the code is a signed trim on top
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      frc_freq_khz_o <= frctd_pkg::FREQ_LOW_KHZ;
      pll_mult_o     <= frctd_pkg::PLL_MULT;
    end else begin
      frc_freq_khz_o <= frc_range_select_i ? frctd_pkg::FREQ_HIGH_KHZ
                                           : frctd_pkg::FREQ_LOW_KHZ;
      pll_mult_o     <= frctd_pkg::PLL_MULT;
    end
  end

  // ----------------------------------------------------------------
  // Source tracking and PLL lock timing
  // ----------------------------------------------------------------
  logic [2:0]  src_q;
  logic        por_q;
  logic        uses_pll;
  logic [15:0] lock_cnt_q;
  logic        lock_q;

  assign uses_pll = (src_q == frctd_pkg::SRC_FRC_PLL) ||
                    (src_q == frctd_pkg::SRC_PRI_PLL);

  // Initial source is captured on the first clock after reset release
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      src_q <= frctd_pkg::SRC_FRC;
      por_q <= 1'b1;
    end else if (por_q) begin
      src_q <= initial_osc_select_i;
      por_q <= 1'b0;
    end else if (switch_start_i) begin
      src_q <= switch_src_i;
    end
  end

  // Wait restarts on every switch and runs only with an input clock
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      lock_cnt_q <= 16'h0000;
      lock_q     <= 1'b0;
    end else if (por_q || switch_start_i || !uses_pll) begin
      lock_cnt_q <= 16'h0000;
      lock_q     <= 1'b0;
    end else if (pll_input_ready_i && !lock_q) begin
      if (lock_cnt_q == 16'(frctd_pkg::LOCK_CYCLES - 1)) begin
        lock_q <= 1'b1;
      end else begin
        lock_cnt_q <= lock_cnt_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Low-power RC enable
  // ----------------------------------------------------------------
  logic low_power_rc_osc_need;

  // Delay select of zero means no power-up timer and no early need
  assign low_power_rc_osc_need = clock_fail_monitor_en_i || watchdog_en_i ||
                     ((powerup_delay_select_i != 3'h0) &&
                      !power_up_timer_done_i);

  // Usable as soon as enabled; no start-up counter is kept
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      low_power_rc_osc_enable_o <= 1'b0;
      low_power_rc_osc_ready_o  <= 1'b0;
    end else begin
      low_power_rc_osc_enable_o <= low_power_rc_osc_need && !sleep_i;
      low_power_rc_osc_ready_o  <= low_power_rc_osc_need && !sleep_i;
    end
  end

  // ----------------------------------------------------------------
  // Read-back
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_low_rdata_o <= 8'h00;
      tune_rdata_o     <= 16'h0000;
      tune2_rdata_o    <= 16'h0000;
      seed_rdata_o     <= 16'h0000;
      pll_lock_flag_o  <= 1'b0;
    end else begin
      ctrl_low_rdata_o <= {2'b00, lock_q, 1'b0, rnd_en_q, seq_en_q, 2'b00};
      tune_rdata_o     <= {code_q[3], code_q[2], code_q[1], code_q[0]};
      tune2_rdata_o    <= {code_q[7], code_q[6], code_q[5], code_q[4]};
      seed_rdata_o     <= {1'b0, lfsr_state};
      pll_lock_flag_o  <= lock_q;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_unlock_gate;
    @(posedge clock_i) disable iff (!rst_n)
    (ctrl_low_we_i && unl_q != UNL_OPEN) |=>
      $stable(seq_en_q) && $stable(rnd_en_q);
  endproperty
  a_unlock_gate: assert property (p_unlock_gate)
    else $error("Dither enable changed without unlock");

  // A first key written while open only shuts the gate, so it is excluded
  sequence s_keys;
    unl_q != UNL_OPEN && ctrl_low_we_i &&
      ctrl_low_wdata_i == frctd_pkg::UNLOCK_KEY1
    ##1 ctrl_low_we_i && ctrl_low_wdata_i == frctd_pkg::UNLOCK_KEY2;
  endsequence
  property p_unlock_open;
    @(posedge clock_i) disable iff (!rst_n)
    s_keys ##1 ctrl_low_we_i |=>
      seq_en_q == $past(ctrl_low_wdata_i[frctd_pkg::SEQEN_BIT]);
  endproperty
  a_unlock_open: assert property (p_unlock_open)
    else $error("Unlocked enable write not taken");

  property p_static_tune;
    @(posedge clock_i) disable iff (!rst_n)
    (!seq_en_q && !rnd_en_q) ##1 (!seq_en_q && !rnd_en_q)
      |-> tune_code_o == $past(code_q[0]);
  endproperty
  a_static_tune: assert property (p_static_tune)
    else $error("Static tune code wrong");

  property p_seq_step;
    @(posedge clock_i) disable iff (!rst_n)
    (retune && seq_en_q && !rnd_en_q) |=>
      seq_idx_q == $past(seq_idx_q) + 3'h1;
  endproperty
  a_seq_step: assert property (p_seq_step)
    else $error("Sequencer did not advance");

  property p_seq_hold;
    @(posedge clock_i) disable iff (!rst_n)
    (seq_en_q && !rnd_en_q && !retune) |=> $stable(seq_idx_q) || !seq_en_q;
  endproperty
  a_seq_hold: assert property (p_seq_hold)
    else $error("Sequencer moved between retunes");

  property p_rnd_latch;
    @(posedge clock_i) disable iff (!rst_n)
    (rnd_en_q && retune && !seed_we_i) |=>
      rnd_code_q == $past(lfsr_state[3:0]);
  endproperty
  a_rnd_latch: assert property (p_rnd_latch)
    else $error("Random code not applied");

  property p_lock_clear;
    @(posedge clock_i) disable iff (!rst_n)
    !uses_pll |=> !lock_q;
  endproperty
  a_lock_clear: assert property (p_lock_clear)
    else $error("Lock set without PLL source");

  property p_lock_switch;
    @(posedge clock_i) disable iff (!rst_n)
    switch_start_i |=> !lock_q ##1 !lock_q;
  endproperty
  a_lock_switch: assert property (p_lock_switch)
    else $error("Lock not cleared on switch");

  property p_low_power_rc_osc_sleep;
    @(posedge clock_i) disable iff (!rst_n)
    sleep_i |=> !low_power_rc_osc_enable_o;
  endproperty
  a_low_power_rc_osc_sleep: assert property (p_low_power_rc_osc_sleep)
    else $error("Low-power RC on in sleep");

endmodule : frctd_ctrl

// file: sim/tb.sv
`timescale 1ns/1ns
module tb;
  // ----------------------------------------------------------------
  // Clock, reset and design inputs
  // ----------------------------------------------------------------
  logic        clock_i        = 1'b0;
  logic        reset_n_i      = 1'b0;
  logic        range_sel      = 1'b0;
  logic [2:0]  init_src       = 3'h1;
  logic [2:0]  pwrup_sel      = 3'h3;
  logic        mon_en         = 1'b0;
  logic        wdog_en        = 1'b0;
  logic        low_we         = 1'b0;
  logic [7:0]  low_wdata      = 8'h00;
  logic [2:0]  reg_we         = 3'b000;
  logic [15:0] reg_wdata      = 16'h0000;
  logic        pwm_cycle      = 1'b0;
  logic        sw_start       = 1'b0;
  logic [2:0]  sw_src         = 3'h0;
  logic        pll_ready      = 1'b1;
  logic        power_up_timer_done      = 1'b0;
  logic        sleep          = 1'b0;
  // Design outputs
  logic [3:0]  tune_code;
  logic [15:0] freq_khz;
  logic [5:0]  pll_mult;
  logic [7:0]  ctrl_rd;
  logic [15:0] tune_rd;
  logic [15:0] tune2_rd;
  logic [15:0] seed_rd;
  logic        lock_flag;
  logic        low_power_rc_osc_en;
  logic        low_power_rc_osc_rdy;
  // Bench bookkeeping
  int          err_count      = 0;
  int          checks_done    = 0;
  logic [3:0]  seq_exp [8]    = '{4'h8, 4'hA, 4'hC, 4'hE,
                                  4'h1, 4'h3, 4'h5, 4'h7};
  // {timer done, watchdog, monitor, sleep, expected enable}
  logic [4:0]  low_power_rc_osc_tab [6]   = '{5'b0_0_0_0_1, 5'b1_0_0_0_0,
                                  5'b1_1_0_0_1, 5'b1_0_1_0_1,
                                  5'b1_0_1_1_0, 5'b0_1_0_1_0};

  // Free-running 10 MHz system clock
  always #50 clock_i = ~clock_i;

  // ----------------------------------------------------------------
  // Device under test
  // ----------------------------------------------------------------
  frctd_ctrl u_frctd_ctrl (
    .clock_i                 (clock_i),
    .reset_n_i               (reset_n_i),
    .frc_range_select_i      (range_sel),
    .initial_osc_select_i    (init_src),
    .powerup_delay_select_i  (pwrup_sel),
    .clock_fail_monitor_en_i (mon_en),
    .watchdog_en_i           (wdog_en),
    .ctrl_low_we_i           (low_we),
    .ctrl_low_wdata_i        (low_wdata),
    .tune_we_i               (reg_we[0]),
    .tune_wdata_i            (reg_wdata),
    .tune2_we_i              (reg_we[1]),
    .tune2_wdata_i           (reg_wdata),
    .seed_we_i               (reg_we[2]),
    .seed_wdata_i            (reg_wdata),
    .pwm_cycle_i             (pwm_cycle),
    .switch_start_i          (sw_start),
    .switch_src_i            (sw_src),
    .pll_input_ready_i       (pll_ready),
    .power_up_timer_done_i   (power_up_timer_done),
    .sleep_i                 (sleep),
    .tune_code_o             (tune_code),
    .frc_freq_khz_o          (freq_khz),
    .pll_mult_o              (pll_mult),
    .ctrl_low_rdata_o        (ctrl_rd),
    .tune_rdata_o            (tune_rd),
    .tune2_rdata_o           (tune2_rd),
    .seed_rdata_o            (seed_rd),
    .pll_lock_flag_o         (lock_flag),
    .low_power_rc_osc_enable_o           (low_power_rc_osc_en),
    .low_power_rc_osc_ready_o            (low_power_rc_osc_rdy)
  );

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  // Inputs always move 10 ns after an edge, never on it
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #10;
  endtask : tick

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Three low-byte writes on consecutive edges, then read-back settles
  task automatic seq3(input logic [7:0] a, b, c);
    low_we    = 1'b1;
    low_wdata = a;
    tick(1);
    low_wdata = b;
    tick(1);
    low_wdata = c;
    tick(1);
    low_we    = 1'b0;
    tick(2);
  endtask : seq3

  // One write to tune (0), tune2 (1) or seed (2)
  task automatic wr_reg(input int sel, input logic [15:0] d);
    reg_we[sel] = 1'b1;
    reg_wdata   = d;
    tick(1);
    reg_we      = 3'b000;
    tick(2);
  endtask : wr_reg

  task automatic pulse(input int n);
    repeat (n) begin
      pwm_cycle = 1'b1;
      tick(1);
      pwm_cycle = 1'b0;
      tick(1);
    end
  endtask : pulse

  task automatic switch_to(input logic [2:0] src);
    sw_src   = src;
    sw_start = 1'b1;
    tick(1);
    sw_start = 1'b0;
    tick(2);
  endtask : switch_to

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  // Hang guard, roughly twelve times the expected run length
  initial begin
    repeat (30000) @(posedge clock_i);
    err_count++;
    $display("watchdog expired before the tests finished");
    conclude();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clock_i);
    #10;
    reset_n_i = 1'b1;
    tick(5);
    chk("seed_reset", 16'h0000, seed_rd);
    chk("pll_mult", 16'd32, {10'd0, pll_mult});
    chk("freq_low", 16'h25e4, freq_khz);
    range_sel = 1'b1;
    tick(3);
    chk("freq_high", 16'h38d6, freq_khz);
    $display("test range done");

    // Power-on source with PLL: flag clear until the lock wait ends
    chk("lock_por", 16'h0000, {15'd0, lock_flag});
    tick(480);
    chk("lock_early", 16'h0000, {15'd0, lock_flag});
    tick(40);
    chk("lock_por_set", 16'h0001, {15'd0, lock_flag});
    chk("lock_bit5", 16'h0001, {15'd0, ctrl_rd[5]});
    switch_to(3'h0);
    chk("lock_frc", 16'h0000, {15'd0, lock_flag});
    tick(600);
    chk("lock_frc_hold", 16'h0000, {15'd0, lock_flag});
    // No clock at the PLL input: the lock wait must not start
    pll_ready = 1'b0;
    switch_to(3'h3);
    tick(600);
    chk("lock_no_input", 16'h0000, {15'd0, lock_flag});
    pll_ready = 1'b1;
    tick(480);
    chk("lock_sw_early", 16'h0000, {15'd0, lock_flag});
    tick(40);
    chk("lock_sw_set", 16'h0001, {15'd0, lock_flag});
    switch_to(3'h1);
    chk("lock_sw_clear", 16'h0000, {15'd0, lock_flag});
    switch_to(3'h0);
    $display("test lock done");

    // Low-power RC enable across its keep-alive conditions
    for (int i = 0; i < 6; i++) begin
      {power_up_timer_done, wdog_en, mon_en, sleep} = low_power_rc_osc_tab[i][4:1];
      tick(3);
      chk("low_power_rc_osc_en", {15'd0, low_power_rc_osc_tab[i][0]}, {15'd0, low_power_rc_osc_en});
      chk("low_power_rc_osc_rdy", {15'd0, low_power_rc_osc_tab[i][0]}, {15'd0, low_power_rc_osc_rdy});
    end
    $display("test low_power_rc_osc done");

    // Static tuning, centre first, then seven codes short of both extremes
    foreach (seq_exp[i]) begin
      wr_reg(0, {12'h000, seq_exp[(i * 3) % 8] ^ 4'h8});
      chk("tune_static", {12'd0, seq_exp[(i * 3) % 8] ^ 4'h8},
          {12'd0, tune_code});
    end
    wr_reg(0, 16'hECA8);
    wr_reg(1, 16'h7531);
    chk("tune_rd", 16'hECA8, tune_rd);
    chk("tune2_rd", 16'h7531, tune2_rd);
    chk("tune_base", 16'h0008, {12'd0, tune_code});
    $display("test tune done");

    // Enable writes without a clean unlock are dropped
    seq3(8'h00, 8'h00, 8'h04);
    chk("no_unlock", 16'h0000, {8'd0, ctrl_rd});
    seq3(8'h46, 8'h56, 8'h04);
    chk("bad_key2", 16'h0000, {8'd0, ctrl_rd});
    seq3(8'h57, 8'h46, 8'h04);
    chk("bad_order", 16'h0000, {8'd0, ctrl_rd});
    seq3(8'h46, 8'h57, 8'h04);
    chk("unlock_seq", 16'h0004, {8'd0, ctrl_rd});
    $display("test unlock done");

    // Sequencer walks base then codes 1..7 and wraps to base
    for (int k = 1; k <= 9; k++) begin
      pulse(7);
      chk("seq_hold", {12'd0, seq_exp[(k - 1) % 8]},
          {12'd0, tune_code});
      pulse(1);
      tick(2);
      chk("seq_step", {12'd0, seq_exp[k % 8]},
          {12'd0, tune_code});
    end
    seq3(8'h46, 8'h57, 8'h00);
    chk("seq_off", 16'h0008, {12'd0, tune_code});
    $display("test sequencer done");

    // Seed load, unimplemented top bit reads zero
    wr_reg(2, 16'hFFFF);
    chk("seed_top", 16'h7FFF, seed_rd);
    wr_reg(2, 16'h1234);
    chk("seed_load", 16'h1234, seed_rd);
    // Random dither with the sequencer bit also set; centre until first draw
    seq3(8'h46, 8'h57, 8'h0C);
    chk("rnd_en", 16'h000C, {8'd0, ctrl_rd});
    pulse(7);
    chk("rnd_hold", 16'h0000, {12'd0, tune_code});
    // First draw takes the seed's low nibble, then the register shifts
    pulse(1);
    tick(2);
    chk("rnd_first", 16'h0004, {12'd0, tune_code});
    chk("seed_step", 16'h2468, seed_rd);
    pulse(7);
    chk("rnd_stable", 16'h0004, {12'd0, tune_code});
    pulse(1);
    tick(2);
    chk("rnd_next", 16'h0008, {12'd0, tune_code});
    $display("test random done");
    conclude();
  end
endmodule : tb
